// file: inc/eeprom_cmd_regs.svh
`ifndef EEPROM_CMD_REGS_SVH
`define EEPROM_CMD_REGS_SVH

// Sampling clock
`define CLK_FREQ_MHZ 100

// Self-timed program cycle lengths, in microseconds
`define WORD8_PROG_TIME_US 1000
`define WORD16_PROG_TIME_US 2000
`define BULK_PROG_TIME_US 15000

// Opcodes following the start bit
`define OPC_SPECIAL 2'h0
`define OPC_WRITE 2'h1
`define OPC_READ 2'h2
`define OPC_ERASE 2'h3

// Qualifier in the two leading address bits of the special opcode
`define SUB_DISABLE 2'h0
`define SUB_WRITE_ALL 2'h1
`define SUB_ERASE_ALL 2'h2
`define SUB_ENABLE 2'h3

// Field lengths per organization
`define OPC_BITS 5'h2
`define ADDR_BITS_WIDE 5'h8
`define ADDR_BITS_NARROW 5'h9
`define DATA_BITS_WIDE 5'h10
`define DATA_BITS_NARROW 5'h8

// Array geometry
`define ARRAY_BYTES 256
`define WIDE_ADDR_MASK 8'h7f

`endif

// file: inc/eeprom_cmd_pkg.sv
`default_nettype none

package eeprom_cmd_pkg;

	typedef enum logic [2:0] {
		CMD_IDLE = 3'h0,
		CMD_OPCODE = 3'h1,
		CMD_ADDRESS = 3'h3,
		CMD_DATA = 3'h2,
		CMD_READ = 3'h6,
		CMD_WAIT_DESELECT = 3'h7
	} cmdState_type;

	typedef enum logic {
		ENG_IDLE = 1'b0,
		ENG_RUN = 1'b1
	} engState_type;

	typedef enum logic [1:0] {
		PROG_ERASE = 2'h0,
		PROG_WRITE = 2'h1,
		PROG_ERASE_ALL = 2'h2,
		PROG_WRITE_ALL = 2'h3
	} progOp_type;

	typedef struct packed {
		progOp_type op;
		logic wide;
		logic [7:0] addr;
		logic [15:0] data;
	} progReq_type;

	typedef struct packed {
		logic chipSelect;
		logic serialClock;
		logic serialDataIn;
		logic orgSelect;
	} linkPins_type;

endpackage

`default_nettype wire

// file: verilog/serial_eeprom_command_port.sv
// Operation
// - Organization high: 128x16; low: 256x8
// - Floating organization pin defaults to x16; no pull-up modelled, orgSelect must be driven
// - Input bits sampled on serial clock rise
// - Output released except read or status
// - Status low while busy, high when ready
// - Output released on serial clock fall
// - Start bit: first rise with select, data high
// - Execute only after all bits clocked in
// - Ignore input after last bit until deselect
// - Opcodes: 10 read, 01 write, 11 erase
// - Wide: 27 or 11 clock cycles
// - Narrow: 20 or 12 clock cycles
// - Read sends dummy zero, then word
// - Read bits change after clock rise
// - Continued clocking reads following words
// - Power-up disables programming, refuses writes
// - Enable persists until disable; reads always work
// - Word erase sets word to ones
// - Select fall starts erase cycle
// - Word 1 ms/2 ms, bulk 15 ms
// - Select fall starts erase-then-write cycle
// - Erase-all sets array to ones
// - Write-all programs without erasing first
// - Deselect resets command logic, cycle continues

`include "eeprom_cmd_regs.svh"

`default_nettype none

module request_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys, // System clock
	input wire logic reset_n, // Async reset
	input wire logic [WIDTH-1:0] inData, // Word to store
	input wire logic inValid, // Word offered
	output logic inReady, // Room for a word
	output logic [WIDTH-1:0] outData, // Oldest word
	output logic outValid, // Word available
	input wire logic outReady // Oldest word taken
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] LAST_SLOT = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] slots;
		logic [PTR_W-1:0] head;
		logic [PTR_W-1:0] tail;
		logic [CNT_W-1:0] count;
	} fifoState_type;

	fifoState_type fifo_reg;
	fifoState_type fifo_next;
	logic doPush;
	logic doPop;

	assign inReady = fifo_reg.count != FULL_COUNT;
	assign outValid = fifo_reg.count != '0;
	assign outData = fifo_reg.slots[fifo_reg.head];
	assign doPush = inValid & inReady;
	assign doPop = outValid & outReady;

	always_comb begin
		fifo_next = fifo_reg;
		if (doPush) begin
			fifo_next.slots[fifo_reg.tail] = inData;
			fifo_next.tail = (fifo_reg.tail == LAST_SLOT) ? '0 :
				fifo_reg.tail + 1'b1;
		end
		if (doPop) begin
			fifo_next.head = (fifo_reg.head == LAST_SLOT) ? '0 :
				fifo_reg.head + 1'b1;
		end
		if (doPush && !doPop) begin
			fifo_next.count = fifo_reg.count + 1'b1;
		end else if (doPop && !doPush) begin
			fifo_next.count = fifo_reg.count - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fifo_reg <= '0;
		end else begin
			fifo_reg <= fifo_next;
		end
	end
endmodule

module serial_eeprom_command_port #(
	parameter int WORD8_CYCLES = `WORD8_PROG_TIME_US * `CLK_FREQ_MHZ,
	parameter int WORD16_CYCLES = `WORD16_PROG_TIME_US * `CLK_FREQ_MHZ,
	parameter int BULK_CYCLES = `BULK_PROG_TIME_US * `CLK_FREQ_MHZ,
	parameter int QUEUE_DEPTH = 4
) (
	input wire logic clk_sys, // System clock, 100 MHz
	input wire logic reset_n, // Async reset, active low
	input wire logic chipSelect, // Chip select pin
	input wire logic serialClock, // Serial clock pin
	input wire logic serialDataIn, // Serial data input pin
	input wire logic orgSelect, // Organization pin, 1 = x16
	output logic serialDataOut, // Serial data output level
	output logic serialDataOutEn, // Serial data output drive
	output logic programBusy, // Program cycle queued or running
	output logic programEnabled // Programming allowed
);
	import eeprom_cmd_pkg::*;

	localparam int REQ_W = $bits(progReq_type);

	typedef struct packed {
		linkPins_type syncA;
		linkPins_type syncB;
		linkPins_type prevB;
		cmdState_type cmd;
		logic [4:0] bitCount;
		logic [1:0] opcode;
		logic [8:0] addrField;
		logic [15:0] dataField;
		logic [7:0] readAddr;
		logic [15:0] readWord;
		logic [4:0] readLeft;
		logic pendValid;
		progReq_type pend;
		logic progEnabled;
		logic statusArm;
		logic dataOut;
		logic dataOutEn;
		engState_type eng;
		progReq_type active;
		logic [31:0] timer;
		logic [`ARRAY_BYTES-1:0][7:0] mem;
	} state_type;

	state_type r;
	state_type n;

	logic sclkRise;
	logic sclkFall;
	logic csLevel;
	logic dinLevel;
	logic wide;
	logic [4:0] addrBits;
	logic [4:0] dataBits;
	logic [8:0] fieldNow;
	logic [15:0] dataNow;
	logic [7:0] addrNow;
	logic [1:0] qualNow;
	logic [15:0] fetched;
	logic [7:0] nextAddr;
	logic busy;
	logic pushValid;
	logic pushReady;
	logic [REQ_W-1:0] popData;
	progReq_type popReq;
	logic popValid;
	logic popReady;

	// Word view of the byte array; x8 words sit in the upper byte
	function automatic logic [15:0] wordAt(
		input logic [`ARRAY_BYTES-1:0][7:0] mem,
		input logic [7:0] addr,
		input logic isWide
	);
		logic [7:0] hiIdx;
		logic [7:0] loIdx;
		hiIdx = {addr[6:0], 1'b0};
		loIdx = {addr[6:0], 1'b1};
		if (isWide) begin
			wordAt = {mem[hiIdx], mem[loIdx]};
		end else begin
			wordAt = {mem[addr], 8'h00};
		end
	endfunction

	request_fifo #(
		.WIDTH(REQ_W),
		.DEPTH(QUEUE_DEPTH)
	) queue (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.inData(r.pend),
		.inValid(pushValid),
		.inReady(pushReady),
		.outData(popData),
		.outValid(popValid),
		.outReady(popReady)
	);

	// Edges taken from the second sync stage only
	assign sclkRise = r.syncB.serialClock & ~r.prevB.serialClock;
	assign sclkFall = ~r.syncB.serialClock & r.prevB.serialClock;
	assign csLevel = r.syncB.chipSelect;
	assign dinLevel = r.syncB.serialDataIn;
	assign wide = r.syncB.orgSelect;
	assign addrBits = wide ? `ADDR_BITS_WIDE : `ADDR_BITS_NARROW;
	assign dataBits = wide ? `DATA_BITS_WIDE : `DATA_BITS_NARROW;
	assign fieldNow = {r.addrField[7:0], dinLevel};
	assign dataNow = {r.dataField[14:0], dinLevel};
	assign addrNow = wide ? {1'b0, fieldNow[6:0]} : fieldNow[7:0];
	assign qualNow = wide ? fieldNow[7:6] : fieldNow[8:7];
	assign fetched = wordAt(r.mem, addrNow, wide);
	assign nextAddr = wide ? ((r.readAddr + 8'h01) & `WIDE_ADDR_MASK) :
		(r.readAddr + 8'h01);
	assign pushValid = r.pendValid & (r.cmd == CMD_IDLE);
	assign popReady = r.eng == ENG_IDLE;
	assign popReq = progReq_type'(popData);
	assign busy = r.pendValid | popValid | (r.eng == ENG_RUN);

	always_comb begin
		n = r;
		n.syncA = '{chipSelect, serialClock, serialDataIn, orgSelect};
		n.syncB = r.syncA;
		n.prevB = r.syncB;

		// Command decoder
		unique case (r.cmd)
			CMD_IDLE: begin
				// New start held off while a request still waits for room
				if (csLevel && sclkRise && dinLevel && !r.pendValid) begin
					n.cmd = CMD_OPCODE;
					n.bitCount = '0;
					n.statusArm = 1'b0;
				end
			end
			CMD_OPCODE: begin
				if (sclkRise) begin
					n.opcode = {r.opcode[0], dinLevel};
					n.bitCount = r.bitCount + 5'h1;
					if (r.bitCount + 5'h1 == `OPC_BITS) begin
						n.cmd = CMD_ADDRESS;
						n.bitCount = '0;
					end
				end
			end
			CMD_ADDRESS: begin
				if (sclkRise) begin
					n.addrField = fieldNow;
					n.bitCount = r.bitCount + 5'h1;
					if (r.bitCount + 5'h1 == addrBits) begin
						n.bitCount = '0;
						n.cmd = CMD_WAIT_DESELECT;
						n.pend.addr = addrNow;
						n.pend.wide = wide;
						n.pend.data = '0;
						unique case (r.opcode)
							`OPC_READ: begin
								n.cmd = CMD_READ;
								n.readAddr = addrNow;
								n.readWord = fetched;
								n.readLeft = dataBits;
								n.dataOut = 1'b0;
								n.dataOutEn = 1'b1;
							end
							`OPC_WRITE: begin
								n.cmd = CMD_DATA;
								n.pend.op = PROG_WRITE;
							end
							`OPC_ERASE: begin
								n.pend.op = PROG_ERASE;
								n.pendValid = r.progEnabled;
							end
							`OPC_SPECIAL: begin
								unique case (qualNow)
									`SUB_ENABLE: n.progEnabled = 1'b1;
									`SUB_DISABLE: n.progEnabled = 1'b0;
									`SUB_ERASE_ALL: begin
										n.pend.op = PROG_ERASE_ALL;
										n.pendValid = r.progEnabled;
									end
									`SUB_WRITE_ALL: begin
										n.cmd = CMD_DATA;
										n.pend.op = PROG_WRITE_ALL;
									end
								endcase
							end
						endcase
					end
				end
			end
			CMD_DATA: begin
				if (sclkRise) begin
					n.dataField = dataNow;
					n.bitCount = r.bitCount + 5'h1;
					if (r.bitCount + 5'h1 == dataBits) begin
						n.cmd = CMD_WAIT_DESELECT;
						n.pend.data = wide ? dataNow : {dataNow[7:0], 8'h00};
						n.pendValid = r.progEnabled;
					end
				end
			end
			CMD_READ: begin
				if (sclkRise) begin
					if (r.readLeft == '0) begin
						n.readAddr = nextAddr;
						n.readWord = {wordAt(r.mem, nextAddr, wide)};
						n.dataOut = n.readWord[15];
						n.readWord = {n.readWord[14:0], 1'b0};
						n.readLeft = dataBits - 5'h1;
					end else begin
						n.dataOut = r.readWord[15];
						n.readWord = {r.readWord[14:0], 1'b0};
						n.readLeft = r.readLeft - 5'h1;
					end
				end
			end
			CMD_WAIT_DESELECT: begin
			end
			default: n.cmd = CMD_IDLE;
		endcase

		// Output drive outside a read or status output ends on a clock fall
		if (sclkFall && r.cmd != CMD_READ) begin
			n.dataOutEn = 1'b0;
		end
		if (csLevel && r.statusArm && r.cmd == CMD_IDLE) begin
			n.dataOutEn = 1'b1;
			n.dataOut = ~busy;
		end

		// Deselect resets decoding; queued program work is untouched
		if (!csLevel) begin
			n.cmd = CMD_IDLE;
			n.bitCount = '0;
			n.dataOutEn = 1'b0;
		end

		if (pushValid && pushReady) begin
			n.pendValid = 1'b0;
			n.statusArm = 1'b1;
		end

		// Program engine
		unique case (r.eng)
			ENG_IDLE: begin
				if (popValid) begin
					n.eng = ENG_RUN;
					n.active = popReq;
					if (popReq.op == PROG_ERASE_ALL ||
						popReq.op == PROG_WRITE_ALL) begin
						n.timer = 32'(BULK_CYCLES - 1);
					end else if (popReq.wide) begin
						n.timer = 32'(WORD16_CYCLES - 1);
					end else begin
						n.timer = 32'(WORD8_CYCLES - 1);
					end
				end
			end
			ENG_RUN: begin
				if (r.timer != '0) begin
					n.timer = r.timer - 32'h1;
				end else begin
					n.eng = ENG_IDLE;
					unique case (r.active.op)
						PROG_ERASE, PROG_WRITE: begin
							if (r.active.wide) begin
								n.mem[{r.active.addr[6:0], 1'b0}] =
									(r.active.op == PROG_ERASE) ? 8'hff :
									r.active.data[15:8];
								n.mem[{r.active.addr[6:0], 1'b1}] =
									(r.active.op == PROG_ERASE) ? 8'hff :
									r.active.data[7:0];
							end else begin
								n.mem[r.active.addr] =
									(r.active.op == PROG_ERASE) ? 8'hff :
									r.active.data[15:8];
							end
						end
						PROG_ERASE_ALL: begin
							for (int i = 0; i < `ARRAY_BYTES; i++) begin
								n.mem[i] = 8'hff;
							end
						end
						PROG_WRITE_ALL: begin
							// Programming only clears bits; no erase first
							for (int i = 0; i < `ARRAY_BYTES; i++) begin
								if (r.active.wide && (i % 2) == 1) begin
									n.mem[i] = r.mem[i] &
										r.active.data[7:0];
								end else begin
									n.mem[i] = r.mem[i] &
										r.active.data[15:8];
								end
							end
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign serialDataOut = r.dataOut;
	assign serialDataOutEn = r.dataOutEn;
	assign programBusy = busy;
	assign programEnabled = r.progEnabled;
endmodule

`default_nettype wire

// file: bench/eeprom_port_monitor.sv
`default_nettype none

module eeprom_port_monitor #(
	parameter int BULK_CYCLES = 1500000,
	parameter int QUEUE_DEPTH = 4
) (
	input wire logic clk_sys, // System clock
	input wire logic reset_n, // Async reset
	input wire logic chipSelect, // Select pin
	input wire logic serialClock, // Link clock pin
	input wire logic serialDataIn, // Data pin in
	input wire logic orgSelect, // Organization pin
	input wire logic serialDataOut, // Data out level
	input wire logic serialDataOutEn, // Data out drive
	input wire logic programBusy, // Program pending
	input wire logic programEnabled // Programming allowed
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BUSY_LIMIT = (QUEUE_DEPTH + 1) * (BULK_CYCLES + 64);
	typedef struct packed {
		logic [3:0] csLow;
		logic [31:0] busyRun;
	} monState_type;
	monState_type mon_reg;
	monState_type mon_next;

	always_comb begin
		mon_next = mon_reg;
		if (chipSelect) begin
			mon_next.csLow = 4'h0;
		end else if (mon_reg.csLow != 4'hf) begin
			mon_next.csLow = mon_reg.csLow + 4'h1;
		end
		mon_next.busyRun = programBusy ? mon_reg.busyRun + 32'h1 : 32'h0;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mon_reg <= '0;
		end else begin
			mon_reg <= mon_next;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	a_reset_quiet: assert property ($rose(reset_n) |->
		!programEnabled && !programBusy && !serialDataOutEn)
		else $error("outputs not idle after reset");
	a_deselect_release: assert property (mon_reg.csLow >= 4'h6 |->
		!serialDataOutEn)
		else $error("output driven while deselected");
	a_drive_selected: assert property ($rose(serialDataOutEn) |->
		chipSelect)
		else $error("output drive began without select");
	a_release_on_fall: assert property ($fell(serialDataOutEn) |->
		!$past(serialClock, 2) || !$past(chipSelect, 2))
		else $error("output released without clock fall");
	a_busy_enabled: assert property ($rose(programBusy) |->
		programEnabled)
		else $error("program started while disabled");
	a_enable_selected: assert property ($changed(programEnabled) |->
		chipSelect)
		else $error("enable changed while deselected");
	a_enable_stable: assert property (!chipSelect [*4] |->
		$stable(programEnabled))
		else $error("enable changed in deselect");
	a_busy_bounded: assert property (mon_reg.busyRun <= BUSY_LIMIT)
		else $error("program cycle too long");

	c_busy: cover property ($rose(programBusy));
	c_disable: cover property ($fell(programEnabled));
	c_status: cover property ($rose(serialDataOutEn) && programBusy);
endmodule

bind serial_eeprom_command_port eeprom_port_monitor #(
	.BULK_CYCLES(BULK_CYCLES),
	.QUEUE_DEPTH(QUEUE_DEPTH)
) i_mon (
	.clk_sys(clk_sys),
	.reset_n(reset_n),
	.chipSelect(chipSelect),
	.serialClock(serialClock),
	.serialDataIn(serialDataIn),
	.orgSelect(orgSelect),
	.serialDataOut(serialDataOut),
	.serialDataOutEn(serialDataOutEn),
	.programBusy(programBusy),
	.programEnabled(programEnabled)
);

`default_nettype wire

// file: bench/host_master.sv
`default_nettype none

module host_master (
	input wire logic clk_sys, // System clock
	output logic chipSelect, // Select to device
	output logic serialClock, // Link clock
	output logic serialDataIn, // Data to device
	input wire logic serialDataOut, // Device output level
	input wire logic serialDataOutEn // Device output drive
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic lineLevel;

	// Pull-up on the released line
	assign lineLevel = serialDataOutEn ? serialDataOut : 1'b1;

	initial begin
		chipSelect = 1'b0;
		serialClock = 1'b0;
		serialDataIn = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic cmd(input int n, input logic [31:0] bits, input int nRd,
		output logic [39:0] rd);
		chipSelect <= 1'b1;
		rd = 40'h0;
		for (int i = n - 1; i >= 0; i--) begin
			serialClock <= 1'b0;
			serialDataIn <= bits[i];
			tick(8);
			serialClock <= 1'b1;
			tick(8);
		end
		serialDataIn <= ~bits[0];
		for (int i = 0; nRd > 0 && i <= nRd; i++) begin
			serialClock <= 1'b0;
			tick(8);
			rd = {rd[38:0], lineLevel};
			// No rise after the last bit: exact clock count
			if (i < nRd) begin
				serialClock <= 1'b1;
				tick(8);
			end
		end
		serialClock <= 1'b0;
		tick(8);
		chipSelect <= 1'b0;
		tick(8);
	endtask

	task automatic status(input int limit, output logic low, output logic ready);
		chipSelect <= 1'b1;
		tick(8);
		low = serialDataOutEn === 1'b1 && lineLevel === 1'b0;
		ready = 1'b0;
		for (int i = 0; i < limit && !ready; i++) begin
			tick(1);
			ready = serialDataOutEn === 1'b1 && lineLevel === 1'b1;
		end
		chipSelect <= 1'b0;
		tick(8);
	endtask
endmodule

`default_nettype wire

// file: bench/tb.sv
`include "eeprom_cmd_regs.svh"
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import eeprom_cmd_pkg::*;
	localparam int W8 = 40;
	localparam int W16 = 60;
	localparam int BULK = 150;
	logic clk_sys, reset_n, orgSelect;
	logic chipSelect, serialClock, serialDataIn;
	logic serialDataOut, serialDataOutEn, programBusy, programEnabled;
	int errors, compares, seed;
	logic [7:0] mem [256];
	logic [39:0] rd;
	logic [7:0] a;
	logic [15:0] d;

	serial_eeprom_command_port #(.WORD8_CYCLES(W8), .WORD16_CYCLES(W16),
		.BULK_CYCLES(BULK), .QUEUE_DEPTH(4)) i_dut (.clk_sys(clk_sys),
		.reset_n(reset_n), .chipSelect(chipSelect), .serialClock(serialClock),
		.serialDataIn(serialDataIn), .orgSelect(orgSelect),
		.serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
		.programBusy(programBusy), .programEnabled(programEnabled));

	host_master i_host (.clk_sys(clk_sys), .chipSelect(chipSelect),
		.serialClock(serialClock), .serialDataIn(serialDataIn),
		.serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic test_done();
		$display("Compares %0d, errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [8:0] fld(input logic [7:0] ad);
		return orgSelect ? {1'b0, ad[6:0], 1'b0} : {1'b0, ad};
	endfunction

	function automatic logic [15:0] word(input logic [7:0] ad);
		return orgSelect ? {mem[{ad[6:0], 1'b0}], mem[{ad[6:0], 1'b1}]}
			: {8'h00, mem[ad]};
	endfunction

	// Field is the address field, left aligned
	task automatic send(input logic [1:0] op, input logic [8:0] field,
		input logic [15:0] dat, input int nRd);
		int n;
		logic [31:0] bits;
		n = orgSelect ? 11 : 12;
		bits = orgSelect ? {21'h0, 1'b1, op, field[8:1]}
			: {20'h0, 1'b1, op, field};
		if (op == `OPC_WRITE || field[8:7] == `SUB_WRITE_ALL && op == 2'h0) begin
			bits = orgSelect ? {bits[15:0], dat} : {bits[23:0], dat[7:0]};
			n += orgSelect ? 16 : 8;
		end
		i_host.cmd(n, bits, nRd, rd);
	endtask

	task automatic prog(input logic [1:0] op, input logic [8:0] field,
		input logic [15:0] dat, input int cyc);
		logic low, ready;
		send(op, field, dat, 0);
		i_host.status(cyc + 40, low, ready);
		cmp({38'h0, low, ready}, 40'h3);
		if (!ready) test_done();
	endtask

	task automatic put(input logic [1:0] op, input logic [7:0] ad,
		input logic [15:0] dat);
		logic [15:0] v;
		v = op == `OPC_ERASE ? 16'hffff : dat;
		prog(op, fld(ad), dat, orgSelect ? W16 : W8);
		if (orgSelect) {mem[{ad[6:0], 1'b0}], mem[{ad[6:0], 1'b1}]} = v;
		else mem[ad] = v[7:0];
	endtask

	task automatic get(input logic [7:0] ad, input int nw);
		int dw;
		logic [39:0] exp;
		dw = orgSelect ? 16 : 8;
		send(`OPC_READ, fld(ad), 16'h0, nw * dw);
		exp = 40'h0;
		for (int i = 0; i < nw; i++)
			exp = (exp << dw) | word(8'(ad + i) & (orgSelect ? 8'h7f : 8'hff));
		cmp(rd, exp);
	endtask

	initial begin
		repeat (90000) @(posedge clk_sys);
		errors++;
		test_done();
	end

	initial begin
		seed = 19;
		errors = 0;
		compares = 0;
		reset_n = 1'b0;
		orgSelect = 1'b1;
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		cmp({38'h0, programEnabled, programBusy}, 40'h0);
		send(`OPC_WRITE, fld(8'h05), 16'h1234, 0);
		repeat (20) @(posedge clk_sys);
		cmp({39'h0, programBusy}, 40'h0);
		get(8'h05, 1);
		send(2'h0, {`SUB_ENABLE, 7'h0}, 16'h0, 0);
		cmp({39'h0, programEnabled}, 40'h1);
		$display("Protection test done");
		for (int k = 1; k >= 0; k--) begin
			orgSelect <= k[0];
			@(posedge clk_sys);
			for (int j = 0; j < 3; j++) begin
				a = j == 0 ? 8'h00 : 8'($random(seed));
				d = 16'($random(seed));
				put(`OPC_WRITE, a, d);
				get(a, 1);
			end
			put(`OPC_ERASE, a, 16'h0);
			get(a, 1);
			get(orgSelect ? 8'h7f : 8'hff, 2);
			$display("Organization %0d test done", k);
		end
		prog(2'h0, {`SUB_ERASE_ALL, 7'h0}, 16'h0, BULK);
		for (int i = 0; i < 256; i++) mem[i] = 8'hff;
		d = 16'($random(seed));
		prog(2'h0, {`SUB_WRITE_ALL, 7'h0}, d, BULK);
		for (int i = 0; i < 256; i++) mem[i] &= d[7:0];
		get(8'($random(seed)), 1);
		// Frame cut inside the data field must not program
		i_host.cmd(15, {17'h0, 1'b1, `OPC_WRITE, 9'h020, 3'h5}, 0, rd);
		repeat (20) @(posedge clk_sys);
		cmp({39'h0, programBusy}, 40'h0);
		get(8'h20, 1);
		$display("Bulk test done");
		send(2'h0, {`SUB_DISABLE, 7'h0}, 16'h0, 0);
		cmp({39'h0, programEnabled}, 40'h0);
		// Extra clocks after the last bit are ignored, line stays released
		send(`OPC_ERASE, fld(8'h10), 16'h0, 4);
		cmp(rd, 40'h1f);
		repeat (20) @(posedge clk_sys);
		cmp({39'h0, programBusy}, 40'h0);
		get(8'h10, 1);
		$display("Disable test done");
		test_done();
	end
endmodule

`default_nettype wire
